// [shared/rcs_pkg.sv]
// shared constants for the sleep, diagnostic and error-status register bank
// assumes a single system clock and a synchronous low-power clock tick input
package rcs_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_SLEEP_CONTROL = 32'h4000_0030;
  localparam logic [31:0] ADDR_SLEEP_WAKEUP_TIME = 32'h4000_0034;
  localparam logic [31:0] ADDR_SLEEP_MEASURED = 32'h4000_0038;
  localparam logic [31:0] ADDR_WAKEUP_IRQ_TIMING = 32'h4000_003C;
  localparam logic [31:0] ADDR_FINE_CORRECTION = 32'h4000_0040;
  localparam logic [31:0] ADDR_BASE_CORRECTION = 32'h4000_0044;
  localparam logic [31:0] ADDR_DIAG_CONTROL = 32'h4000_0050;
  localparam logic [31:0] ADDR_DIAG_STATUS = 32'h4000_0054;
  localparam logic [31:0] ADDR_ZONE_UPPER = 32'h4000_0058;
  localparam logic [31:0] ADDR_ZONE_LOWER = 32'h4000_005C;
  localparam logic [31:0] ADDR_ERROR_STATUS = 32'h4000_0060;

  // reset value shared by every register of the bank
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // sleep control fields
  localparam int SC_EXT_WAKE_DISABLE_BIT = 31;
  localparam int SC_SLEEP_STATUS_BIT = 15;
  localparam int SC_SW_WAKE_BIT = 4;
  localparam int SC_CORR_EN_BIT = 3;
  localparam int SC_SLEEP_REQ_BIT = 2;
  localparam int SC_IRQ_EN_LSB = 0;
  localparam int SC_IRQ_EN_W = 2;
  localparam logic [1:0] IRQ_EN_ALL = 2'h3;

  // wake interrupt timing fields, in low-power clock cycles
  localparam int TW_EXT_LSB = 21;
  localparam int TW_EXT_W = 11;
  localparam int TW_SET_LSB = 10;
  localparam int TW_SET_W = 11;
  localparam int TW_RESET_LSB = 0;
  localparam int TW_RESET_W = 10;

  // correction value widths
  localparam int FINE_CORR_W = 10;
  localparam int BASE_CORR_W = 27;

  // diagnostic port layout: one byte lane per port in control and status
  localparam int NUM_DIAG = 4;
  localparam int DIAG_W = 8;
  localparam int DIAG_SEL_W = 6;
  localparam int DIAG_EN_OFS = 7;

  // debug address zone limits
  localparam int ZONE_W = 16;
  localparam int REG_ZONE_LSB = 16;
  localparam int EM_ZONE_LSB = 0;

  // error status bits
  localparam int ERR_LSB = 1;
  localparam int ERR_MSB = 17;
  localparam int ERR_UNACKED_EVENT_IRQ = 17;
  localparam int ERR_NULL_RX_BUFFER = 16;
  localparam int ERR_NULL_TX_BUFFER = 15;
  localparam int ERR_NULL_RX_DESCRIPTOR = 14;
  localparam int ERR_NULL_TX_DESCRIPTOR = 13;
  localparam int ERR_BAD_STRUCTURE_FORMAT = 12;
  localparam int ERR_CHANNEL_MAP_COUNT = 11;
  localparam int ERR_ADVERTISING_UNDERRUN = 10;
  localparam int ERR_INTERFRAME_UNDERRUN = 9;
  localparam int ERR_ALLOW_LIST_TIMEOUT = 8;
  localparam int ERR_EVENT_CTRL_PREFETCH = 7;
  localparam int ERR_SCHEDULER_PREFETCH = 6;
  localparam int ERR_SCHEDULER_ENTRY = 5;
  localparam int ERR_SCHEDULER_MEMORY = 4;
  localparam int ERR_RADIO_MEMORY = 3;
  localparam int ERR_PACKET_MEMORY = 2;
  localparam int ERR_RX_DECRYPT_LATE = 1;

  typedef enum logic [2:0] {
    RCS_ACTIVE = 3'b001,
    RCS_SLEEP = 3'b010,
    RCS_WOKEN = 3'b100
  } rcs_sleep_state_e;

endpackage

// [shared/rcs_diag_if.sv]
// carrier between the register bank and one diagnostic port
// assumes the bank drives enable and select, the port returns its value
`timescale 1ns/1ps
`default_nettype none
interface rcs_diag_if;
  logic enable;
  logic [rcs_pkg::DIAG_SEL_W-1:0] select;
  logic [rcs_pkg::DIAG_W-1:0] value;
  modport ctrl (output enable, output select, input value);
  modport port (input enable, input select, output value);
endinterface
`default_nettype wire

// [core/rcs_diag_port.sv]
// one diagnostic port: selects a byte among the internal signal groups
// assumes source groups are synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module rcs_diag_port #(
  parameter int SEL_W = rcs_pkg::DIAG_SEL_W,
  parameter int GRP_W = rcs_pkg::DIAG_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [(2**SEL_W)*GRP_W-1:0] sources_in,
  rcs_diag_if.port dport
);

  generate
    if (SEL_W != rcs_pkg::DIAG_SEL_W || GRP_W != rcs_pkg::DIAG_W) begin : g_bad
      $error("diagnostic port widths must match the interface");
    end
  endgenerate

  // a disabled port drives all zeros whatever its select holds
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dport.value <= '0;
    end else if (dport.enable) begin
      dport.value <= sources_in[dport.select*GRP_W +: GRP_W];
    end else begin
      dport.value <= '0;
    end
  end

endmodule
`default_nettype wire

// [core/rcs_sleep_diag_bank.sv]
// deep-sleep control, diagnostic port and error-status register bank
// assumes lp_tick_in marks one low-power clock cycle, synchronous to clk_in
// assumes event inputs are one-cycle pulses synchronous to clk_in
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rcs_sleep_diag_bank #(
  parameter int DIAG_SEL_W = rcs_pkg::DIAG_SEL_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  input wire logic lp_tick_in,
  input wire logic ext_wake_in,
  output logic sleep_status_out,
  output logic low_power_wake_interrupt_out,
  output logic timer_correction_out,
  output logic [rcs_pkg::FINE_CORR_W-1:0] fine_phase_correction_out,
  output logic [rcs_pkg::BASE_CORR_W-1:0] base_time_correction_value_out,
  input wire logic [(2**DIAG_SEL_W)*rcs_pkg::DIAG_W-1:0] diag_sources_in,
  output logic [rcs_pkg::NUM_DIAG*rcs_pkg::DIAG_W-1:0] diag_port_out,
  input wire logic [rcs_pkg::ZONE_W-1:0] reg_access_addr_in,
  input wire logic [rcs_pkg::ZONE_W-1:0] em_access_addr_in,
  output logic register_zone_flag_out,
  output logic exchange_zone_flag_out,
  input wire logic [rcs_pkg::ERR_MSB:rcs_pkg::ERR_LSB] error_event_in,
  input wire logic error_ack_in
);

  generate
    if (DIAG_SEL_W != rcs_pkg::DIAG_SEL_W) begin : g_bad_sel
      $error("diagnostic select width is fixed by the register layout");
    end
  endgenerate

  // register storage
  rcs_pkg::rcs_sleep_state_e state;
  logic ext_wake_disable;
  logic software_wake_request;
  logic sleep_request;
  logic [rcs_pkg::SC_IRQ_EN_W-1:0] wake_irq_enable;
  logic [31:0] sleep_time_cycles;
  logic [31:0] measured_sleep_cycles;
  logic [rcs_pkg::TW_EXT_W-1:0] external_wake_deassert_delay;
  logic [rcs_pkg::TW_SET_W-1:0] wake_irq_set_lead;
  logic [rcs_pkg::TW_RESET_W-1:0] wake_irq_reset_lead;
  logic [31:0] diag_control;
  logic [rcs_pkg::ZONE_W-1:0] register_zone_upper;
  logic [rcs_pkg::ZONE_W-1:0] exchange_zone_upper;
  logic [rcs_pkg::ZONE_W-1:0] register_zone_lower;
  logic [rcs_pkg::ZONE_W-1:0] exchange_zone_lower;
  logic [rcs_pkg::ERR_MSB:rcs_pkg::ERR_LSB] error_status;
  logic ext_delay_active;
  logic [rcs_pkg::TW_EXT_W-1:0] ext_delay_count;

  // write decode
  logic wr_sleep_control;
  logic wr_sleep_time;
  logic wr_irq_timing;
  logic wr_fine_corr;
  logic wr_base_corr;
  logic wr_diag_control;
  logic wr_zone_upper;
  logic wr_zone_lower;

  assign wr_sleep_control = wr_en_in && addr_in == rcs_pkg::ADDR_SLEEP_CONTROL;
  assign wr_sleep_time = wr_en_in && addr_in == rcs_pkg::ADDR_SLEEP_WAKEUP_TIME;
  assign wr_irq_timing = wr_en_in && addr_in == rcs_pkg::ADDR_WAKEUP_IRQ_TIMING;
  assign wr_fine_corr = wr_en_in && addr_in == rcs_pkg::ADDR_FINE_CORRECTION;
  assign wr_base_corr = wr_en_in && addr_in == rcs_pkg::ADDR_BASE_CORRECTION;
  assign wr_diag_control = wr_en_in && addr_in == rcs_pkg::ADDR_DIAG_CONTROL;
  assign wr_zone_upper = wr_en_in && addr_in == rcs_pkg::ADDR_ZONE_UPPER;
  assign wr_zone_lower = wr_en_in && addr_in == rcs_pkg::ADDR_ZONE_LOWER;

  // sleep timing terms
  logic in_sleep;
  logic irq_generation_on;
  logic [31:0] next_measured;
  logic [31:0] remaining;
  logic timer_expire;
  logic ext_wake_go;
  logic sw_wake_go;
  logic leave_sleep;
  logic enter_sleep;
  logic correction_go;

  assign in_sleep = state == rcs_pkg::RCS_SLEEP;
  assign irq_generation_on = wake_irq_enable == rcs_pkg::IRQ_EN_ALL;
  assign next_measured = measured_sleep_cycles + 32'h1;
  assign remaining = sleep_time_cycles - next_measured;
  assign timer_expire = in_sleep && lp_tick_in
    && next_measured >= sleep_time_cycles;
  assign ext_wake_go = in_sleep && ext_wake_in
    && !ext_wake_disable;
  assign sw_wake_go = in_sleep && software_wake_request;
  assign leave_sleep = timer_expire || ext_wake_go || sw_wake_go;
  assign enter_sleep = state == rcs_pkg::RCS_ACTIVE && sleep_request;
  assign correction_go = wr_sleep_control
    && wr_data_in[rcs_pkg::SC_CORR_EN_BIT]
    && state == rcs_pkg::RCS_WOKEN;

  // power state: sleeping, woken with timers held, or active
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= rcs_pkg::RCS_ACTIVE;
      sleep_status_out <= 1'b0;
    end else begin
      case (state)
        rcs_pkg::RCS_ACTIVE: begin
          if (enter_sleep) begin
            state <= rcs_pkg::RCS_SLEEP;
            sleep_status_out <= 1'b1;
          end
        end
        rcs_pkg::RCS_SLEEP: begin
          if (leave_sleep) begin
            state <= rcs_pkg::RCS_WOKEN;
            sleep_status_out <= 1'b0;
          end
        end
        rcs_pkg::RCS_WOKEN: begin
          if (correction_go) begin
            state <= rcs_pkg::RCS_ACTIVE;
          end
        end
        default: begin
          state <= rcs_pkg::RCS_ACTIVE;
          sleep_status_out <= 1'b0;
        end
      endcase
    end
  end

  // sleep control register fields
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_wake_disable <= 1'b0;
      wake_irq_enable <= '0;
    end else if (wr_sleep_control) begin
      ext_wake_disable <= wr_data_in[rcs_pkg::SC_EXT_WAKE_DISABLE_BIT];
      wake_irq_enable <=
        wr_data_in[rcs_pkg::SC_IRQ_EN_LSB +: rcs_pkg::SC_IRQ_EN_W];
    end
  end

  // sleep request falls with the sleep status
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_request <= 1'b0;
    end else if (in_sleep && leave_sleep) begin
      sleep_request <= 1'b0;
    end else if (wr_sleep_control) begin
      sleep_request <= wr_data_in[rcs_pkg::SC_SLEEP_REQ_BIT];
    end
  end

  // software wake only latches while asleep and clears once acted on
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      software_wake_request <= 1'b0;
    end else if (sw_wake_go) begin
      software_wake_request <= 1'b0;
    end else if (wr_sleep_control && in_sleep
        && wr_data_in[rcs_pkg::SC_SW_WAKE_BIT]) begin
      software_wake_request <= 1'b1;
    end
  end

  // correction strobe towards the fine and base time counters
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_correction_out <= 1'b0;
    end else begin
      timer_correction_out <= correction_go;
    end
  end

  // sleep duration settings
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_time_cycles <= rcs_pkg::REG_RESET;
    end else if (wr_sleep_time) begin
      sleep_time_cycles <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      measured_sleep_cycles <= rcs_pkg::REG_RESET;
    end else if (enter_sleep) begin
      measured_sleep_cycles <= '0;
    end else if (in_sleep && lp_tick_in) begin
      measured_sleep_cycles <= next_measured;
    end
  end

  // wake interrupt lead and external delay fields
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      external_wake_deassert_delay <= '0;
      wake_irq_set_lead <= '0;
      wake_irq_reset_lead <= '0;
    end else if (wr_irq_timing) begin
      external_wake_deassert_delay <=
        wr_data_in[rcs_pkg::TW_EXT_LSB +: rcs_pkg::TW_EXT_W];
      wake_irq_set_lead <=
        wr_data_in[rcs_pkg::TW_SET_LSB +: rcs_pkg::TW_SET_W];
      wake_irq_reset_lead <=
        wr_data_in[rcs_pkg::TW_RESET_LSB +: rcs_pkg::TW_RESET_W];
    end
  end

  // low-power wake interrupt: timer leads while asleep, delay after external
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_power_wake_interrupt_out <= 1'b0;
      ext_delay_active <= 1'b0;
      ext_delay_count <= '0;
    end else if (ext_wake_go) begin
      low_power_wake_interrupt_out <= irq_generation_on;
      ext_delay_active <= irq_generation_on;
      ext_delay_count <= external_wake_deassert_delay;
    end else if (ext_delay_active && lp_tick_in) begin
      if (ext_delay_count <= rcs_pkg::TW_EXT_W'(1)) begin
        low_power_wake_interrupt_out <= 1'b0;
        ext_delay_active <= 1'b0;
      end else begin
        ext_delay_count <= ext_delay_count - rcs_pkg::TW_EXT_W'(1);
      end
    end else if (in_sleep && lp_tick_in && irq_generation_on) begin
      if (remaining == 32'(wake_irq_reset_lead)) begin
        low_power_wake_interrupt_out <= 1'b0;
      end else if (remaining == 32'(wake_irq_set_lead)) begin
        low_power_wake_interrupt_out <= 1'b1;
      end
    end
  end

  // correction values
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fine_phase_correction_out <= '0;
    end else if (wr_fine_corr) begin
      fine_phase_correction_out <= wr_data_in[rcs_pkg::FINE_CORR_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_time_correction_value_out <= '0;
    end else if (wr_base_corr) begin
      base_time_correction_value_out <= wr_data_in[rcs_pkg::BASE_CORR_W-1:0];
    end
  end

  // diagnostic ports
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      diag_control <= rcs_pkg::REG_RESET;
    end else if (wr_diag_control) begin
      diag_control <= wr_data_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < rcs_pkg::NUM_DIAG; g++) begin : g_diag
      rcs_diag_if dif ();
      assign dif.enable =
        diag_control[g*rcs_pkg::DIAG_W + rcs_pkg::DIAG_EN_OFS];
      assign dif.select =
        diag_control[g*rcs_pkg::DIAG_W +: rcs_pkg::DIAG_SEL_W];
      rcs_diag_port #(
        .SEL_W(DIAG_SEL_W),
        .GRP_W(rcs_pkg::DIAG_W)
      ) u_port (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sources_in(diag_sources_in),
        .dport(dif.port)
      );
      assign diag_port_out[g*rcs_pkg::DIAG_W +: rcs_pkg::DIAG_W] = dif.value;
    end
  endgenerate

  // debug zone limits and in-zone flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      register_zone_upper <= '0;
      exchange_zone_upper <= '0;
    end else if (wr_zone_upper) begin
      register_zone_upper <= wr_data_in[rcs_pkg::REG_ZONE_LSB +: rcs_pkg::ZONE_W];
      exchange_zone_upper <= wr_data_in[rcs_pkg::EM_ZONE_LSB +: rcs_pkg::ZONE_W];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      register_zone_lower <= '0;
      exchange_zone_lower <= '0;
    end else if (wr_zone_lower) begin
      register_zone_lower <= wr_data_in[rcs_pkg::REG_ZONE_LSB +: rcs_pkg::ZONE_W];
      exchange_zone_lower <= wr_data_in[rcs_pkg::EM_ZONE_LSB +: rcs_pkg::ZONE_W];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      register_zone_flag_out <= 1'b0;
      exchange_zone_flag_out <= 1'b0;
    end else begin
      register_zone_flag_out <= reg_access_addr_in >= register_zone_lower
        && reg_access_addr_in <= register_zone_upper;
      exchange_zone_flag_out <= em_access_addr_in >= exchange_zone_lower
        && em_access_addr_in <= exchange_zone_upper;
    end
  end

  // sticky error flags; a new event in the acknowledge cycle stays set
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_status <= '0;
    end else begin
      error_status <= (error_status & {17{!error_ack_in}}) | error_event_in;
    end
  end

  // read path: data stand in the cycle after the strobe, else zero
  logic [31:0] next_rd_data;

  always_comb begin
    next_rd_data = '0;
    case (addr_in)
      rcs_pkg::ADDR_SLEEP_CONTROL: begin
        next_rd_data[rcs_pkg::SC_EXT_WAKE_DISABLE_BIT] = ext_wake_disable;
        next_rd_data[rcs_pkg::SC_SLEEP_STATUS_BIT] = sleep_status_out;
        next_rd_data[rcs_pkg::SC_SW_WAKE_BIT] = software_wake_request;
        next_rd_data[rcs_pkg::SC_SLEEP_REQ_BIT] = sleep_request;
        next_rd_data[rcs_pkg::SC_IRQ_EN_LSB +: rcs_pkg::SC_IRQ_EN_W] =
          wake_irq_enable;
      end
      rcs_pkg::ADDR_SLEEP_WAKEUP_TIME: next_rd_data = sleep_time_cycles;
      rcs_pkg::ADDR_SLEEP_MEASURED: next_rd_data = measured_sleep_cycles;
      rcs_pkg::ADDR_WAKEUP_IRQ_TIMING: begin
        next_rd_data[rcs_pkg::TW_EXT_LSB +: rcs_pkg::TW_EXT_W] =
          external_wake_deassert_delay;
        next_rd_data[rcs_pkg::TW_SET_LSB +: rcs_pkg::TW_SET_W] =
          wake_irq_set_lead;
        next_rd_data[rcs_pkg::TW_RESET_LSB +: rcs_pkg::TW_RESET_W] =
          wake_irq_reset_lead;
      end
      rcs_pkg::ADDR_FINE_CORRECTION: begin
        next_rd_data[rcs_pkg::FINE_CORR_W-1:0] = fine_phase_correction_out;
      end
      rcs_pkg::ADDR_BASE_CORRECTION: begin
        next_rd_data[rcs_pkg::BASE_CORR_W-1:0] = base_time_correction_value_out;
      end
      rcs_pkg::ADDR_DIAG_CONTROL: begin
        for (int p = 0; p < rcs_pkg::NUM_DIAG; p++) begin
          next_rd_data[p*rcs_pkg::DIAG_W + rcs_pkg::DIAG_EN_OFS] =
            diag_control[p*rcs_pkg::DIAG_W + rcs_pkg::DIAG_EN_OFS];
          next_rd_data[p*rcs_pkg::DIAG_W +: rcs_pkg::DIAG_SEL_W] =
            diag_control[p*rcs_pkg::DIAG_W +: rcs_pkg::DIAG_SEL_W];
        end
      end
      rcs_pkg::ADDR_DIAG_STATUS: next_rd_data = diag_port_out;
      rcs_pkg::ADDR_ZONE_UPPER: begin
        next_rd_data = {register_zone_upper, exchange_zone_upper};
      end
      rcs_pkg::ADDR_ZONE_LOWER: begin
        next_rd_data = {register_zone_lower, exchange_zone_lower};
      end
      rcs_pkg::ADDR_ERROR_STATUS: begin
        next_rd_data[rcs_pkg::ERR_MSB:rcs_pkg::ERR_LSB] = error_status;
      end
      default: next_rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= rcs_pkg::REG_RESET;
    end else if (rd_en_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule
`default_nettype wire

// [verification/rcs_bank_assertions.sv]
// assertions on the sleep, diagnostic and error-status bank ports
// assumes the bind below attaches it to every bank instance
`timescale 1ns/1ps
`default_nettype none
module rcs_bank_assertions (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic lp_tick_in,
  input wire logic sleep_status_out,
  input wire logic low_power_wake_interrupt_out,
  input wire logic timer_correction_out,
  input wire logic [31:0] diag_port_out,
  input wire logic [17:1] error_event_in,
  input wire logic error_ack_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic woken;
  wire wsc = wr_en_in && addr_in == rcs_pkg::ADDR_SLEEP_CONTROL;
  wire rerr = rd_en_in && addr_in == rcs_pkg::ADDR_ERROR_STATUS;
  // woken after a sleep phase until correction is applied
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) woken <= 1'b0;
    else if ($fell(sleep_status_out)) woken <= 1'b1;
    else if (timer_correction_out) woken <= 1'b0;
  end
  sequence err_read;
    error_event_in != 0 && !error_ack_in ##1 rerr && !error_ack_in;
  endsequence
  sequence ack_read;
    error_ack_in && error_event_in == 0 ##1 rerr;
  endsequence
  AST_ERR_SET: assert property (
    err_read |=> (rd_data_out[17:1] & $past(error_event_in, 2))
      == $past(error_event_in, 2)) else $error("error bit lost");
  AST_ERR_ACK: assert property (
    ack_read |=> rd_data_out == 0) else $error("error not cleared");
  AST_SLEEP_ENTER: assert property (
    wsc && wr_data_in[2] && !sleep_status_out && !woken
      |=> ##1 sleep_status_out) else $error("no sleep entry");
  AST_CORR: assert property (
    wsc && wr_data_in[3] && woken |=> timer_correction_out)
    else $error("no correction pulse");
  AST_SW_WAKE: assert property (
    sleep_status_out && wsc && wr_data_in[4] |=> ##[0:1] !sleep_status_out)
    else $error("no soft wake");
  AST_STAT_BIT: assert property (
    rd_en_in && addr_in == rcs_pkg::ADDR_SLEEP_CONTROL
      |=> rd_data_out[15] == $past(sleep_status_out))
    else $error("sleep status bit wrong");
  AST_IRQ_TICK: assert property (
    $fell(low_power_wake_interrupt_out) |-> $past(lp_tick_in))
    else $error("irq dropped off tick");
  AST_DIAG_OFF: assert property (
    wr_en_in && addr_in == rcs_pkg::ADDR_DIAG_CONTROL
      && (wr_data_in & 32'h8080_8080) == 0 ##1 !wr_en_in
      |=> diag_port_out == 0) else $error("disabled port drives");
  AST_DIAG_STAT: assert property (
    rd_en_in && addr_in == rcs_pkg::ADDR_DIAG_STATUS
      |=> rd_data_out == $past(diag_port_out)) else $error("diag stat");
endmodule
bind rcs_sleep_diag_bank rcs_bank_assertions chk_u (.clk_in, .rst_n_in,
  .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .lp_tick_in,
  .sleep_status_out, .low_power_wake_interrupt_out, .timer_correction_out,
  .diag_port_out, .error_event_in, .error_ack_in);
`default_nettype wire

// [verification/tb_rcs_sleep_diag_bank.sv]
// self-checking bench for the sleep, diagnostic and error-status bank
// assumes the bank drives read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module tb_rcs_sleep_diag_bank;
  localparam logic [31:0] SC = rcs_pkg::ADDR_SLEEP_CONTROL;
  logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0;
  logic lp_tick_in = 0, ext_wake_in = 0, error_ack_in = 0;
  logic [31:0] addr_in = '0, wr_data_in = '0, rd_data_out, diag_port_out;
  logic [511:0] diag_sources_in;
  logic [15:0] reg_access_addr_in = '0, em_access_addr_in = '0;
  logic [17:1] error_event_in = '0;
  logic sleep_status_out, low_power_wake_interrupt_out, timer_correction_out;
  logic register_zone_flag_out, exchange_zone_flag_out;
  logic [9:0] fine_phase_correction_out;
  logic [26:0] base_time_correction_value_out;
  int fails = 0, compares = 0;
  always #2.5 clk_in = ~clk_in;
  rcs_sleep_diag_bank dut_u (.clk_in, .rst_n_in, .addr_in, .wr_data_in,
    .wr_en_in, .rd_en_in, .rd_data_out, .lp_tick_in, .ext_wake_in,
    .sleep_status_out, .low_power_wake_interrupt_out, .timer_correction_out,
    .fine_phase_correction_out, .base_time_correction_value_out,
    .diag_sources_in, .diag_port_out, .reg_access_addr_in, .em_access_addr_in,
    .register_zone_flag_out, .exchange_zone_flag_out, .error_event_in,
    .error_ack_in);
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  // read strobe edge also ends any error event or acknowledge pulse
  task automatic rdc(input logic [31:0] a, exp, input string what);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    error_event_in <= '0;
    error_ack_in <= 1'b0;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(what, exp, rd_data_out);
  endtask
  task automatic tick;
    @(posedge clk_in);
    lp_tick_in <= 1'b1;
    @(posedge clk_in);
    lp_tick_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic t_regs;
    logic [31:0] a[6] = '{32'h4000_0034, 32'h4000_003C, 32'h4000_0040,
      32'h4000_0044, 32'h4000_0058, 32'h4000_005C};
    logic [31:0] m[6] = '{'1, '1, 32'h0000_03FF, 32'h07FF_FFFF, '1, '1};
    for (int i = 0; i < 6; i++) begin
      rdc(a[i], '0, "reset value");
      wr(a[i], '1);
      rdc(a[i], m[i], "written value");
    end
    chk("fine out", 32'h0000_03FF, 32'(fine_phase_correction_out));
    chk("base out", 32'h07FF_FFFF, 32'(base_time_correction_value_out));
    reg_access_addr_in <= 16'hFFFF;
    repeat (2) @(posedge clk_in);
    #1 chk("zone", 32'h1, 32'(register_zone_flag_out));
    chk("em zone", '0, 32'(exchange_zone_flag_out));
    wr(32'h4000_0038, '1);
    rdc(32'h4000_0038, '0, "read-only");
    rdc(32'h4000_004C, '0, "unmapped");
    $display("register test done");
  endtask
  task automatic t_diag;
    wr(32'h4000_0050, 32'h00BF_0985);
    repeat (2) @(posedge clk_in);
    #1 chk("diag out", 32'h009A_00A0, diag_port_out);
    rdc(32'h4000_0054, 32'h009A_00A0, "diag status");
    wr(32'h4000_0050, 32'h0000_0905);
    repeat (2) @(posedge clk_in);
    #1 chk("diag off", '0, diag_port_out);
    $display("diagnostic test done");
  endtask
  task automatic t_sleep;
    int up = 0;
    int dn = 0;
    wr(32'h4000_0034, 32'h0000_0014);
    wr(32'h4000_003C, 32'h00A0_1801);
    wr(SC, 32'h0000_0007);
    for (int n = 1; n <= 20; n++) begin
      if (n == 20) chk("asleep", 32'h1, 32'(sleep_status_out));
      tick;
      if (low_power_wake_interrupt_out && up == 0) up = n;
      if (!low_power_wake_interrupt_out && up != 0 && dn == 0) dn = n;
    end
    chk("irq set tick", 32'h0000_000E, up);
    chk("irq reset tick", 32'h0000_0013, dn);
    chk("woke", '0, 32'(sleep_status_out));
    rdc(32'h4000_0038, 32'h0000_0014, "measured");
    rdc(SC, 32'h0000_0003, "request cleared");
    wr(SC, 32'h0000_000B);
    #1 chk("correction", 32'h1, 32'(timer_correction_out));
    $display("sleep timer test done");
  endtask
  task automatic t_wake;
    wr(SC, 32'h0000_0007);
    wr(SC, 32'h0000_0017);
    repeat (2) @(posedge clk_in);
    #1 chk("soft wake", '0, 32'(sleep_status_out));
    wr(SC, 32'h0000_000B);
    wr(SC, 32'h0000_000B);
    #1 chk("late correction", '0, 32'(timer_correction_out));
    wr(SC, 32'h8000_0007);
    ext_wake_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk("ext blocked", 32'h1, 32'(sleep_status_out));
    wr(SC, 32'h0000_0007);
    repeat (3) @(posedge clk_in);
    #1 chk("ext wake", '0, 32'(sleep_status_out));
    chk("ext irq", 32'h1, 32'(low_power_wake_interrupt_out));
    ext_wake_in <= 1'b0;
    repeat (5) tick;
    chk("ext irq drop", '0, 32'(low_power_wake_interrupt_out));
    wr(SC, 32'h0000_000B);
    $display("wake test done");
  endtask
  task automatic pulse(input logic [17:1] ev, input logic ack);
    @(posedge clk_in);
    error_event_in <= ev;
    error_ack_in <= ack;
  endtask
  task automatic t_err;
    pulse(17'h1_5555, 1'b0);
    rdc(32'h4000_0060, 32'h0002_AAAA, "errors");
    pulse(17'h0_AAAA, 1'b0);
    rdc(32'h4000_0060, 32'h0003_FFFE, "errors kept");
    pulse(17'h0_0001, 1'b1);
    rdc(32'h4000_0060, 32'h0000_0002, "ack race");
    pulse('0, 1'b1);
    rdc(32'h4000_0060, '0, "acked");
    $display("error test done");
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 64; k++) diag_sources_in[8*k+:8] <= 8'(k) ^ 8'hA5;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_diag;
    t_sleep;
    t_wake;
    t_err;
    end_of_test;
  end
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
